//--- pkg/twe_pkg.sv
package twe_pkg;

  // register map, byte address on the wishbone bus
  localparam logic [7:0] PORT_ADDR = 8'h90;
  localparam int CLK_BIT = 2;
  localparam int DATA_BIT = 1;
  localparam int PWR_BIT = 0;
  localparam logic [2:0] PORT_RESET = 3'h7;
  localparam int PORT_BITS = 3;

  // memory and write buffer
  localparam int MEM_DEPTH = 128;
  localparam int MEM_AW = 7;
  localparam int BUF_DEPTH = 16;
  localparam int BUF_AW = 4;

  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WRITE_TIME_US = 2000;
  localparam int TIMER_W = 16;

  // bit order matches the register: clk at bit 2, data at bit 1, power at bit 0
  typedef struct packed {
    logic clk;
    logic data;
    logic power;
  } twe_port_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_MACK = 5'h10
  } twe_state_t;

  typedef enum logic [2:0] {
    PH_CTRL = 3'h1,
    PH_ADDR = 3'h2,
    PH_DATA = 3'h4
  } twe_phase_t;

endpackage : twe_pkg

//--- hw/twe_eeprom_port.sv
// Functional notes
// (RULE_01) 128 nonvolatile byte locations, reachable only over the two-wire bus.
// (RULE_02) data line is port register bit 1, clock line bit 2, register at 90h.
// (RULE_03) power bit 1 powers memory; 0 removes power and tri-states memory pins.
// (RULE_04) data bit 1 releases the data line, 0 drives it low.
// (RULE_05) clock bit sets the clock line level directly.
// (RULE_06) upper five register bits read as zero.
// (RULE_07) with power off, clock, data and power bits all read zero.
// (RULE_08) master starts a transfer only while both lines are high.
// (RULE_09) data changing while clock high is a start or stop condition.
// (RULE_10) data falling while clock high is a start condition.
// (RULE_11) data rising while clock high is a stop condition.
// (RULE_12) one bit per clock pulse, valid while high, changes while low.
// (RULE_13) unlimited bytes per write; only last sixteen kept, oldest overwritten first.
// (RULE_14) slave acknowledges every received byte on a ninth clock pulse.
// (RULE_15) no acknowledge while an internal programming cycle runs.
// (RULE_16) acknowledge holds data low through the whole high acknowledge clock.
// (RULE_17) master withholds ack on last read byte; slave leaves data released.
// (RULE_18) control byte: 4-bit type code, three don't-care bits, direction bit.
// (RULE_19) control byte acknowledged only on code match and no programming cycle.
// (RULE_20) byte write: control, word address into pointer, data, each acknowledged.
// (RULE_21) stop after write data starts timed write cycle; no acks until done.
// (RULE_22) master polls with start and write control byte until acknowledged.
// (RULE_23) address pointer increments by one after each access.
// (RULE_24) only low seven bits of the word address select a location.
`timescale 1ns/1ps
module twe_eeprom_port #(
  parameter int WRITE_CYCLES = twe_pkg::WRITE_TIME_US * 1000 / twe_pkg::CLK_PERIOD_NS,
  // device type code, value arbitrary
  parameter logic [3:0] DEV_CODE = 4'h5
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic mem_power_out,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic scl_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic sda_in
);

  localparam logic [twe_pkg::TIMER_W-1:0] WRITE_LAST =
    twe_pkg::TIMER_W'(WRITE_CYCLES - 1);
  localparam logic [4:0] BUF_FULL = 5'(twe_pkg::BUF_DEPTH);

  // ---------------- wishbone slave and port register ----------------
  logic ack_reg;
  logic [31:0] dat_reg;
  twe_pkg::twe_port_t port_reg;

  wire bus_req = wb_cyc_in & wb_stb_in;
  wire port_hit = (wb_adr_in[7:2] == twe_pkg::PORT_ADDR[7:2]);
  wire port_wr = ack_reg & wb_we_in & port_hit & wb_sel_in[0];
  wire pwr = port_reg.power;
  logic sda_filt_reg;
  wire [7:0] port_rd = pwr ? {5'h00, port_reg.clk, sda_filt_reg, port_reg.power}
                           : 8'h00; // see RULE_06 see RULE_07

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = dat_reg;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (bus_req & ~ack_reg) begin
        dat_reg <= port_hit ? {24'h00_0000, port_rd} : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      port_reg <= twe_pkg::twe_port_t'(twe_pkg::PORT_RESET);
    end else if (port_wr) begin
      port_reg <= twe_pkg::twe_port_t'(wb_dat_in[twe_pkg::PORT_BITS-1:0]); // see RULE_02
    end
  end

  // ---------------- pins ----------------
  logic slave_low_reg;

  assign mem_power_out = pwr; // see RULE_03
  assign scl_out = port_reg.clk; // see RULE_05
  assign scl_oe_out = pwr; // see RULE_03
  assign sda_out = 1'b0;
  assign sda_oe_out = pwr & (~port_reg.data | slave_low_reg); // see RULE_04

  // ---------------- line sampling ----------------
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_filt_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_filt_reg <= 1'b1;
      sda_filt_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_filt_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_filt_reg <= sda_sync_reg[2];
      end
      scl_prev_reg <= scl_filt_reg;
      sda_prev_reg <= sda_filt_reg;
    end
  end

  wire scl_rise = scl_filt_reg & ~scl_prev_reg; // see RULE_12
  wire scl_fall = ~scl_filt_reg & scl_prev_reg;
  wire scl_held = scl_filt_reg & scl_prev_reg;
  wire start_det = scl_held & sda_prev_reg & ~sda_filt_reg; // see RULE_09 see RULE_10
  wire stop_det = scl_held & ~sda_prev_reg & sda_filt_reg; // see RULE_09 see RULE_11

  // ---------------- slave state ----------------
  twe_pkg::twe_state_t state_reg;
  twe_pkg::twe_phase_t phase_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic read_dir_reg;
  logic master_ack_reg;
  logic [twe_pkg::MEM_AW-1:0] ptr_reg;
  logic busy_reg;
  logic [twe_pkg::TIMER_W-1:0] timer_reg;
  logic [7:0] mem [twe_pkg::MEM_DEPTH]; // see RULE_01
  logic [7:0] buf_data [twe_pkg::BUF_DEPTH];
  logic [twe_pkg::MEM_AW-1:0] buf_addr [twe_pkg::BUF_DEPTH];
  logic [twe_pkg::BUF_AW-1:0] buf_wr_idx_reg;
  logic [4:0] buf_cnt_reg;

  wire in_rx = (state_reg == twe_pkg::ST_RX);
  wire byte_done = in_rx & scl_fall & (bit_cnt_reg == 4'h8); // see RULE_14
  wire ctrl_match = (shift_reg[7:4] == DEV_CODE) & ~busy_reg; // see RULE_18 see RULE_19
  wire ctrl_byte = byte_done & (phase_reg == twe_pkg::PH_CTRL);
  wire ctrl_ok = ctrl_byte & ctrl_match;
  wire addr_byte = byte_done & (phase_reg == twe_pkg::PH_ADDR);
  wire data_byte = byte_done & (phase_reg == twe_pkg::PH_DATA);
  wire write_open = ctrl_ok & ~shift_reg[0];
  wire [7:0] mem_rd = mem[ptr_reg];
  wire tx_load = scl_fall & (((state_reg == twe_pkg::ST_ACK) & read_dir_reg)
                 | ((state_reg == twe_pkg::ST_MACK) & master_ack_reg));
  wire commit = busy_reg & (buf_cnt_reg != 5'h00);
  wire [twe_pkg::BUF_AW-1:0] buf_rd_idx = buf_wr_idx_reg - buf_cnt_reg[3:0];
  wire write_start = pwr & stop_det & ~busy_reg & (buf_cnt_reg != 5'h00); // see RULE_21
  wire [twe_pkg::MEM_AW-1:0] ptr_inc = ptr_reg + 7'h01;

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= twe_pkg::ST_IDLE;
      phase_reg <= twe_pkg::PH_CTRL;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      read_dir_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      slave_low_reg <= 1'b0;
    end else if (~pwr) begin
      state_reg <= twe_pkg::ST_IDLE;
      slave_low_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= twe_pkg::ST_RX;
      phase_reg <= twe_pkg::PH_CTRL;
      bit_cnt_reg <= 4'h0;
      slave_low_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= twe_pkg::ST_IDLE;
      slave_low_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        twe_pkg::ST_IDLE: begin
        end
        twe_pkg::ST_RX: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            shift_reg <= {shift_reg[6:0], sda_filt_reg}; // see RULE_12
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done) begin
            if (ctrl_byte && !ctrl_match) begin
              state_reg <= twe_pkg::ST_IDLE; // see RULE_15
            end else begin
              state_reg <= twe_pkg::ST_ACK;
              slave_low_reg <= 1'b1; // see RULE_14 see RULE_16
            end
            if (ctrl_byte) begin
              read_dir_reg <= shift_reg[0];
            end
          end
        end
        twe_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (read_dir_reg) begin
              state_reg <= twe_pkg::ST_TX;
              shift_reg <= mem_rd;
              slave_low_reg <= ~mem_rd[7];
            end else begin
              state_reg <= twe_pkg::ST_RX; // see RULE_20
              slave_low_reg <= 1'b0;
              phase_reg <= (phase_reg == twe_pkg::PH_CTRL) ? twe_pkg::PH_ADDR
                                                          : twe_pkg::PH_DATA;
            end
          end
        end
        twe_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= twe_pkg::ST_MACK;
              slave_low_reg <= 1'b0;
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              slave_low_reg <= ~shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        twe_pkg::ST_MACK: begin
          if (scl_rise) begin
            master_ack_reg <= ~sda_filt_reg;
          end
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (master_ack_reg) begin
              state_reg <= twe_pkg::ST_TX;
              shift_reg <= mem_rd;
              slave_low_reg <= ~mem_rd[7];
            end else begin
              state_reg <= twe_pkg::ST_IDLE; // see RULE_17
            end
          end
        end
      endcase
    end
  end

  // address pointer
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ptr_reg <= 7'h00;
    end else if (addr_byte) begin
      ptr_reg <= shift_reg[6:0]; // see RULE_24
    end else if (data_byte || (pwr && tx_load)) begin
      ptr_reg <= ptr_inc; // see RULE_23
    end
  end

  // write buffer ring: oldest entry is overwritten once sixteen are held
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      buf_wr_idx_reg <= 4'h0;
      buf_cnt_reg <= 5'h00;
    end else if (write_open) begin
      buf_cnt_reg <= 5'h00;
    end else if (data_byte) begin
      buf_wr_idx_reg <= buf_wr_idx_reg + 4'h1; // see RULE_13
      if (buf_cnt_reg != BUF_FULL) begin
        buf_cnt_reg <= buf_cnt_reg + 5'h01;
      end
    end else if (commit) begin
      buf_cnt_reg <= buf_cnt_reg - 5'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (data_byte) begin
      buf_data[buf_wr_idx_reg] <= shift_reg;
      buf_addr[buf_wr_idx_reg] <= ptr_reg;
    end
    if (commit) begin
      mem[buf_addr[buf_rd_idx]] <= buf_data[buf_rd_idx];
    end
  end

  // internally timed write cycle
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_reg <= 1'b0;
      timer_reg <= '0;
    end else if (write_start) begin
      busy_reg <= 1'b1; // see RULE_21
      timer_reg <= '0;
    end else if (busy_reg) begin
      if (timer_reg == WRITE_LAST) begin
        busy_reg <= 1'b0;
      end
      timer_reg <= timer_reg + 1'b1;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  sequence seq_ack_cycle;
    (state_reg == twe_pkg::ST_ACK) && scl_rise;
  endsequence

  sequence seq_tx_start;
    tx_load && pwr && !start_det && !stop_det;
  endsequence

  chk_upper_bits_zero: assert property (wb_ack_out |-> wb_dat_out[7:3] == 5'h00) // see RULE_06
    else $error("unimplemented port bits read nonzero");

  chk_power_off_read: assert property ( // see RULE_07
    wb_ack_out && port_hit && !pwr && $past(!pwr) |-> wb_dat_out[2:0] == 3'h0)
    else $error("port bits not zero while memory unpowered");

  chk_power_tristate: assert property (!pwr |-> !scl_oe_out && !sda_oe_out) // see RULE_03
    else $error("memory pins driven while unpowered");

  chk_clock_level: assert property (pwr |-> scl_oe_out && scl_out == port_reg.clk) // see RULE_05
    else $error("clock line does not follow clock bit");

  chk_data_low: assert property ( // see RULE_04
    pwr && !port_reg.data |-> sda_oe_out && !sda_out)
    else $error("data line not driven low for data bit 0");

  chk_ack_held_low: assert property (seq_ack_cycle |-> slave_low_reg && sda_oe_out) // see RULE_16
    else $error("acknowledge not held low during clock high");

  chk_no_ack_busy: assert property ( // see RULE_15
    busy_reg && ctrl_byte && !start_det && !stop_det |=> state_reg == twe_pkg::ST_IDLE)
    else $error("control byte accepted during write cycle");

  chk_start_rx: assert property ( // see RULE_10
    pwr && start_det |=> in_rx && bit_cnt_reg == 4'h0 && phase_reg == twe_pkg::PH_CTRL)
    else $error("start condition not detected");

  chk_stop_idle: assert property ( // see RULE_11
    pwr && stop_det && !start_det |=> state_reg == twe_pkg::ST_IDLE && !slave_low_reg)
    else $error("stop condition not detected");

  chk_ptr_increment: assert property ( // see RULE_23
    seq_tx_start |=> ptr_reg == $past(ptr_inc))
    else $error("pointer did not advance after read");

  chk_buffer_bound: assert property (buf_cnt_reg <= BUF_FULL) // see RULE_13
    else $error("write buffer count above sixteen");

  chk_write_start: assert property ( // see RULE_21
    write_start |=> busy_reg ##1 busy_reg)
    else $error("write cycle not started by stop");

  chk_bus_ack_drop: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("bus acknowledge held longer than one cycle");

endmodule : twe_eeprom_port

//--- tb/twe_bus_model.sv
`timescale 1ns/1ps
// the two bus wires with their external pull-ups
module twe_bus_model (
  input wire logic scl_out_in,
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic scl_line_out,
  output logic sda_line_out
);
  // released or unpowered pins float up to the pull-up level
  assign scl_line_out = scl_oe_in ? scl_out_in : 1'b1;
  assign sda_line_out = sda_oe_in ? 1'b0 : 1'b1;
endmodule : twe_bus_model

//--- tb/twe_eeprom_port_tb.sv
`timescale 1ns/1ps
module twe_eeprom_port_tb;
  localparam int WCYC = 3000;
  // device type code, value arbitrary
  localparam logic [3:0] CODE = 4'h5;
  localparam logic [7:0] CW = {CODE, 3'b000, 1'b0};
  localparam logic [7:0] CR = {CODE, 3'b000, 1'b1};
  localparam logic [7:0] PA = twe_pkg::PORT_ADDR;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack, pwr, scl_o, scl_oe, sda_o, sda_oe, scl_l, sda_l, ak;
  logic [7:0] b;
  int n_fail = 0;
  int samples_checked = 0;

  twe_eeprom_port #(.WRITE_CYCLES(WCYC), .DEV_CODE(CODE)) twe_eeprom_port_i (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .mem_power_out(pwr), .scl_out(scl_o),
    .scl_oe_out(scl_oe), .scl_in(scl_l), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .sda_in(sda_l));

  twe_bus_model twe_bus_model_i (.scl_out_in(scl_o), .scl_oe_in(scl_oe),
    .sda_oe_in(sda_oe), .scl_line_out(scl_l), .sda_line_out(sda_l));

  initial forever #25 mclk_in = ~mclk_in;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic wb(input logic w, input logic [7:0] a, input logic [2:0] d);
    int n = 0;
    @(posedge mclk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {29'h0, d};
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk({31'h0, ack}, 32'h1);
  endtask : wb

  // one register write moving the lines, then time for the pins to settle
  task automatic ln(input logic c, input logic d);
    wb(1'b1, PA, {c, d, 1'b1});
    repeat (10) @(posedge mclk_in);
  endtask : ln

  task automatic start_c;
    ln(1'b0, 1'b1);
    ln(1'b1, 1'b1);
    ln(1'b1, 1'b0);
    ln(1'b0, 1'b0);
  endtask : start_c

  task automatic stop_c;
    ln(1'b0, 1'b0);
    ln(1'b1, 1'b0);
    ln(1'b1, 1'b1);
  endtask : stop_c

  task automatic tx(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      ln(1'b0, v[i]);
      ln(1'b1, v[i]);
      ln(1'b0, v[i]);
    end
    ln(1'b0, 1'b1);
    ln(1'b1, 1'b1);
    wb(1'b0, PA, 3'h0);
    ak = ~rd[1];
    repeat (6) @(posedge mclk_in);
    chk({31'h0, sda_oe}, {31'h0, ak});
    ln(1'b0, 1'b1);
  endtask : tx

  task automatic rx(input logic mack);
    for (int i = 7; i >= 0; i--) begin
      ln(1'b1, 1'b1);
      wb(1'b0, PA, 3'h0);
      b[i] = rd[1];
      ln(1'b0, 1'b1);
    end
    ln(1'b0, ~mack);
    ln(1'b1, ~mack);
    wb(1'b0, PA, 3'h0);
    if (!mack) chk(rd, 32'h7);
    ln(1'b0, ~mack);
    ln(1'b0, 1'b1);
  endtask : rx

  task automatic poll;
    int n = 0;
    ak = 1'b0;
    while (!ak && n < 20) begin
      start_c;
      tx(CW);
      if (!ak) stop_c;
      n++;
    end
    chk({31'h0, ak}, 32'h1);
  endtask : poll

  initial begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    wb(1'b0, PA, 3'h0);
    chk(rd, 32'h7);
    chk({27'h0, pwr, scl_o, scl_oe, sda_oe, sda_o}, 32'h1c);
    wb(1'b0, 8'h94, 3'h0);
    chk(rd, 32'h0);
    wb(1'b1, PA, 3'h6);
    repeat (10) @(posedge mclk_in);
    chk({29'h0, pwr, scl_oe, sda_oe}, 32'h0);
    wb(1'b0, PA, 3'h0);
    chk(rd, 32'h0);
    ln(1'b0, 1'b0);
    chk({30'h0, scl_l, sda_l}, 32'h0);
    wb(1'b0, PA, 3'h0);
    chk(rd, 32'h1);
    ln(1'b1, 1'b1);
    chk({30'h0, scl_l, sda_l}, 32'h3);
    start_c;
    tx(CW);
    chk({31'h0, ak}, 32'h1);
    tx(8'h90);
    chk({31'h0, ak}, 32'h1);
    tx(8'h3c);
    chk({31'h0, ak}, 32'h1);
    stop_c;
    start_c;
    tx(CW);
    chk({31'h0, ak}, 32'h0);
    stop_c;
    poll;
    tx(8'h10);
    for (int i = 0; i < 17; i++) begin
      tx(8'h40 + 8'(i));
      chk({31'h0, ak}, 32'h1);
    end
    stop_c;
    poll;
    tx(8'h10);
    start_c;
    tx(CR);
    chk({31'h0, ak}, 32'h1);
    rx(1'b1);
    chk({24'h0, b}, 32'h3c);
    rx(1'b1);
    chk({24'h0, b}, 32'h41);
    rx(1'b0);
    chk({24'h0, b}, 32'h42);
    stop_c;
    start_c;
    tx(CR);
    rx(1'b0);
    chk({24'h0, b}, 32'h43);
    stop_c;
    start_c;
    tx({CODE ^ 4'h1, 3'b000, 1'b0});
    chk({31'h0, ak}, 32'h0);
    stop_c;
    summarize;
  end

  // watchdog well beyond the expected run of about 17000 cycles
  initial begin
    repeat (90000) @(posedge mclk_in);
    n_fail++;
    summarize;
  end
endmodule : twe_eeprom_port_tb
